// >>> hdl/pll_status_pkg.sv
package pll_status_pkg;

   // ****************************************************************
   // register map (byte addresses, one aligned word each)
   // ****************************************************************
   localparam logic [3:0] cal_status_addr = 4'h0;
   localparam logic [3:0] lock_status_addr = 4'h4;
   localparam logic [3:0] event_flags_addr = 4'h8;
   localparam logic [3:0] loss_count_addr = 4'hc;
   localparam logic [4:0] lock_config_addr = 5'h10;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int cal_fail_bit = 7;
   localparam int cal_done_bit = 6;
   localparam int band_msb = 5;
   localparam int lock_bit = 0;
   localparam int rail_low_bit = 1;
   localparam int rail_high_bit = 2;
   localparam int count_msb = 3;
   localparam int cfg_timer_lsb = 0;
   localparam int cfg_sticky_bit = 2;
   localparam int cfg_cal_byp_bit = 3;
   localparam int cfg_bypass_bit = 4;

   // ****************************************************************
   // reset values and timing counts
   // ****************************************************************
   localparam logic [4:0] lock_config_reset = 5'h02;
   localparam logic [3:0] count_max = 4'hf;
   localparam int debounce_short = 570;
   localparam int debounce_mid = 5700;
   localparam int debounce_long = 57000;
   localparam int debounce_width = 16;

   // ****************************************************************
   // axi responses
   // ****************************************************************
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // analog loop observations
   typedef struct packed {
      logic cal_done;
      logic cal_fail;
      logic [5:0] band;
      logic locked;
      logic rail_high;
      logic rail_low;
   } loop_obs_t;

   // lock detector configuration
   typedef struct packed {
      logic bypass;
      logic cal_byp;
      logic sticky;
      logic [1:0] timer;
   } lock_cfg_t;

endpackage

// >>> hdl/lock_debounce.sv
`timescale 1ns/1ps

// ****************************************************************
// lock qualification: enable gate, bypass, debounce, sticky hold
// ****************************************************************
module lock_debounce (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire pll_status_pkg::lock_cfg_t cfg,
   input wire logic cal_done,
   input wire logic raw_lock,
   // result
   output logic lock_out
);

   logic [pll_status_pkg::debounce_width-1:0] count;
   logic [pll_status_pkg::debounce_width-1:0] limit;
   logic detector_on;
   logic raw_gated;
   logic next_lock;

   // detector runs only after calibration unless the bypass says so
   assign detector_on = cfg.cal_byp | cal_done;
   assign raw_gated = raw_lock & detector_on;

   // interval lookup; zero means the raw level passes straight
   always_comb begin
      unique case (cfg.timer)
         2'h0: limit = '0;
         2'h1: limit = pll_status_pkg::debounce_width'
            (pll_status_pkg::debounce_short);
         2'h2: limit = pll_status_pkg::debounce_width'
            (pll_status_pkg::debounce_mid);
         2'h3: limit = pll_status_pkg::debounce_width'
            (pll_status_pkg::debounce_long);
      endcase
   end

   // forced lock wins; sticky mode keeps an asserted lock
   always_comb begin
      if (cfg.bypass) begin
         next_lock = 1'b1;
      end else if (cfg.sticky && lock_out) begin
         next_lock = 1'b1;
      end else if (raw_gated == lock_out) begin
         next_lock = lock_out;
      end else begin
         next_lock = (count >= limit) ? raw_gated : lock_out;
      end
   end

   // counter restarts whenever the raw level agrees with the output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         lock_out <= 1'b0;
      end else begin
         if (raw_gated == lock_out || count >= limit) begin
            count <= '0;
         end else begin
            count <= count + 1'b1;
         end
         lock_out <= next_lock;
      end
   end

endmodule

// >>> hdl/pll_status_event_logic.sv
`timescale 1ns/1ps

module pll_status_event_logic (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // analog loop observations (asynchronous)
   input wire pll_status_pkg::loop_obs_t loop_in,
   // axi4-lite write address
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   pll_status_pkg::loop_obs_t sync_a;
   pll_status_pkg::loop_obs_t obs;

   // the analog side is unclocked; first stage is read only by second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a <= '0;
         obs <= '0;
      end else begin
         sync_a <= loop_in;
         obs <= sync_a;
      end
   end

   // ****************************************************************
   // state
   // ****************************************************************
   pll_status_pkg::lock_cfg_t cfg;
   logic lock_q;
   logic lock_prev;
   logic [2:0] flags;
   logic [3:0] loss_count;
   logic [7:0] cal_reg;
   logic [7:0] stat_reg;

   lock_debounce u_lock (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg),
      .cal_done(obs.cal_done),
      .raw_lock(obs.locked),
      .lock_out(lock_q)
   );

   // ****************************************************************
   // write channel
   // ****************************************************************
   logic [4:0] aw_hold;
   logic aw_have;
   logic [31:0] w_hold;
   logic [3:0] ws_hold;
   logic w_have;
   logic do_write;
   logic [4:0] wr_addr;
   logic [31:0] wr_data;
   logic lane0;
   logic wr_flags;
   logic wr_count;
   logic wr_cfg;
   logic wr_hit;

   // a side taken alone sets its holder; with both held or taken the write fires once
   assign wr_addr = aw_have ? aw_hold : s_axi_awaddr;
   assign wr_data = w_have ? w_hold : s_axi_wdata;
   assign lane0 = w_have ? ws_hold[0] : s_axi_wstrb[0];
   assign do_write = (aw_have | (s_axi_awvalid & s_axi_awready))
      & (w_have | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
   assign wr_flags = do_write & lane0
      & (wr_addr == {1'b0, pll_status_pkg::event_flags_addr});
   assign wr_count = do_write & lane0
      & (wr_addr == {1'b0, pll_status_pkg::loss_count_addr});
   assign wr_cfg = do_write & lane0
      & (wr_addr == pll_status_pkg::lock_config_addr);
   assign wr_hit = (wr_addr == {1'b0, pll_status_pkg::cal_status_addr})
      | (wr_addr == {1'b0, pll_status_pkg::lock_status_addr})
      | (wr_addr == {1'b0, pll_status_pkg::event_flags_addr})
      | (wr_addr == {1'b0, pll_status_pkg::loss_count_addr})
      | (wr_addr == pll_status_pkg::lock_config_addr);

   // ready pulses for one cycle while nothing of that kind is held and no response pends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_hold <= '0;
         w_hold <= '0;
         ws_hold <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pll_status_pkg::resp_okay;
      end else begin
         if (do_write) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? pll_status_pkg::resp_okay
               : pll_status_pkg::resp_slverr;
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_have <= 1'b1;
               aw_hold <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_have <= 1'b1;
               w_hold <= s_axi_wdata;
               ws_hold <= s_axi_wstrb;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_awready <= ~aw_have & ~s_axi_awready & ~s_axi_bvalid
            & ~do_write;
         s_axi_wready <= ~w_have & ~s_axi_wready & ~s_axi_bvalid
            & ~do_write;
      end
   end

   // ****************************************************************
   // event flags and loss-of-lock counter
   // ****************************************************************
   logic lock_drop;
   logic [2:0] events;
   logic [2:0] next_flags;
   logic [3:0] next_count;

   assign lock_drop = lock_prev & ~lock_q;
   assign events = {obs.rail_high, obs.rail_low, lock_drop};
   // a set in the clearing cycle survives; zeros written do nothing
   assign next_flags = (flags & ~({3{wr_flags}} & wr_data[2:0]))
      | events;
   always_comb begin
      if (wr_count) begin
         next_count = wr_data[pll_status_pkg::count_msb:0];
      end else if (lock_drop && loss_count != pll_status_pkg::count_max)
      begin
         next_count = loss_count + 4'h1;
      end else begin
         next_count = loss_count;
      end
   end

   // register updates; reset zeroes all but cfg, which takes lock_config_reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
         loss_count <= '0;
         lock_prev <= 1'b0;
         cfg <= pll_status_pkg::lock_cfg_t'
            (pll_status_pkg::lock_config_reset);
      end else begin
         flags <= next_flags;
         loss_count <= next_count;
         lock_prev <= lock_q;
         if (wr_cfg) begin
            cfg <= pll_status_pkg::lock_cfg_t'(wr_data[4:0]);
         end
      end
   end

   // ****************************************************************
   // read channel
   // ****************************************************************
   logic [7:0] rd_byte;
   logic rd_hit;

   // status images: band and outcome only shown once done
   assign cal_reg = {obs.cal_done & obs.cal_fail, obs.cal_done,
      obs.cal_done ? obs.band : 6'h00};
   assign stat_reg = {5'h00, obs.rail_high, obs.rail_low,
      lock_q};
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         {1'b0, pll_status_pkg::cal_status_addr}: rd_byte = cal_reg;
         {1'b0, pll_status_pkg::lock_status_addr}: rd_byte = stat_reg;
         {1'b0, pll_status_pkg::event_flags_addr}:
            rd_byte = {5'h00, flags};
         {1'b0, pll_status_pkg::loss_count_addr}:
            rd_byte = {4'h0, loss_count};
         pll_status_pkg::lock_config_addr: rd_byte = {3'h0, cfg};
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // one read at a time; answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= pll_status_pkg::resp_okay;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? pll_status_pkg::resp_okay
               : pll_status_pkg::resp_slverr;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid
            & ~(s_axi_arvalid & s_axi_arready);
      end
   end

endmodule

// >>> sim/pll_loop_model.sv
`timescale 1ns/1ps

// ****************
// analog loop stand-in
// ****************
module pll_loop_model (
   // observed loop levels
   output pll_status_pkg::loop_obs_t loop_out
);
   // levels move only when the bench asks, just after a clock edge
   initial loop_out = '0;
   task automatic set_cal(input logic d, input logic f, input logic [5:0] b);
      loop_out.cal_done <= d;
      loop_out.cal_fail <= f;
      loop_out.band <= b;
   endtask
   task automatic set_lock(input logic v);
      loop_out.locked <= v;
   endtask
   task automatic set_rails(input logic h, input logic l);
      loop_out.rail_high <= h;
      loop_out.rail_low <= l;
   endtask
endmodule

// >>> sim/pll_status_event_logic_properties.sv
`timescale 1ns/1ps

// ****************
// bus and register checks
// ****************
module pll_status_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // loop levels
   input wire pll_status_pkg::loop_obs_t loop_in,
   // bus
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [2:0] calm;
   logic [4:0] rd_addr;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire settled = calm == 3'h7;
   // quiet-cycle count, so checks skip the synchroniser delay
   always_ff @(posedge aclk) begin
      if (!aresetn || !$stable(loop_in))
         calm <= 3'h0;
      else if (!settled)
         calm <= calm + 3'h1;
      if (ar_take)
         rd_addr <= s_axi_araddr;
   end
   AST_CAL_READ: assert property (
      ar_take && s_axi_araddr == 5'h00 && settled |=> s_axi_rdata[7:0] ==
      (loop_in.cal_done ? {loop_in.cal_fail, 1'b1, loop_in.band} : 8'h00))
      else $error("cal status read mismatch");
   AST_RAIL_STATUS: assert property (
      ar_take && s_axi_araddr == 5'h04 && settled |=>
      s_axi_rdata[7:1] == {5'h00, loop_in.rail_high, loop_in.rail_low})
      else $error("rail status read mismatch");
   AST_RAIL_EVENT: assert property (
      ar_take && s_axi_araddr == 5'h08 && settled |=> s_axi_rdata[2] >=
      loop_in.rail_high && s_axi_rdata[1] >= loop_in.rail_low)
      else $error("rail event flag not set");
   AST_READ_ANSWER: assert property (ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read answer repeated");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write answer repeated");
   AST_UNMAPPED: assert property (ar_take && s_axi_araddr == 5'h14 |=>
      s_axi_rresp == pll_status_pkg::resp_slverr && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_UPPER_ZERO: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 &&
      (rd_addr != 5'h0c || s_axi_rdata[7:4] == 4'h0))
      else $error("reserved read bits set");
   AST_RESET_IDLE: assert property (
      $rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid)
      else $error("answer pending after reset");
   cover property (ar_take && s_axi_araddr == 5'h08);
   cover property (ar_take && s_axi_araddr == 5'h0c);
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind pll_status_event_logic pll_status_props i_pll_status_props (
   .aclk, .aresetn, .loop_in, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// >>> sim/pll_status_event_logic_tb.sv
`timescale 1ns/1ps

// ****************
// register bench
// ****************
module pll_status_event_logic_tb;
   localparam logic [1:0] ok = pll_status_pkg::resp_okay;
   localparam logic [1:0] se = pll_status_pkg::resp_slverr;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   pll_status_pkg::loop_obs_t loop_in;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   logic s_axi_bready, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [3:0] lanes;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   pll_status_event_logic i_pll_status_event_logic (.aclk, .aresetn,
      .loop_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   pll_loop_model i_pll_loop_model (.loop_out(loop_in));
   always #20 aclk = ~aclk;
   // watchdog: a hung handshake would otherwise stall the run
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         close_out;
      end
   end
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_data(input string w, input logic [31:0] e, s);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", w, e, s);
      end
   endtask
   task automatic chk_resp(input string w, input logic [1:0] e, s);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", w, e, s);
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] a, input logic [7:0] d,
                     input logic [1:0] e);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= lanes;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk_resp($sformatf("bresp@%h", a), e, s_axi_bresp);
      @(posedge aclk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] x,
                     input logic [1:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk_data($sformatf("rdata@%h", a), {24'h0, x}, s_axi_rdata);
      chk_resp($sformatf("rresp@%h", a), e, s_axi_rresp);
      @(posedge aclk);
   endtask
   // covers the two-flop synchroniser plus status register
   task automatic settle;
      repeat (8) @(posedge aclk);
   endtask
   // main sequence: lock debounce on at reset, off from the first config write until the last step
   initial begin
      lanes = 4'hf;
      s_axi_awaddr <= '0;
      s_axi_araddr <= '0;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      s_axi_wdata <= '0;
      s_axi_wstrb <= '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 4; i++)
         rd(5'(4 * i), 8'h00, ok);
      rd(5'h10, 8'h02, ok);
      rd(5'h14, 8'h00, se);
      wr(5'h10, 8'h00, ok);
      i_pll_loop_model.set_cal(1'b0, 1'b1, 6'h2a);
      i_pll_loop_model.set_lock(1'b1);
      settle;
      rd(5'h00, 8'h00, ok);
      rd(5'h04, 8'h00, ok);
      i_pll_loop_model.set_cal(1'b1, 1'b1, 6'h2a);
      settle;
      rd(5'h00, 8'hea, ok);
      rd(5'h04, 8'h01, ok);
      i_pll_loop_model.set_rails(1'b1, 1'b0);
      settle;
      rd(5'h04, 8'h05, ok);
      i_pll_loop_model.set_rails(1'b0, 1'b1);
      settle;
      rd(5'h04, 8'h03, ok);
      wr(5'h08, 8'h02, ok);
      rd(5'h08, 8'h06, ok);
      i_pll_loop_model.set_rails(1'b0, 1'b0);
      settle;
      wr(5'h08, 8'h00, ok);
      rd(5'h08, 8'h06, ok);
      wr(5'h08, 8'h02, ok);
      rd(5'h08, 8'h04, ok);
      wr(5'h08, 8'h04, ok);
      i_pll_loop_model.set_lock(1'b0);
      settle;
      rd(5'h08, 8'h01, ok);
      rd(5'h0c, 8'h01, ok);
      i_pll_loop_model.set_lock(1'b1);
      settle;
      wr(5'h08, 8'h01, ok);
      rd(5'h08, 8'h00, ok);
      wr(5'h0c, 8'h0e, ok);
      for (int i = 0; i < 2; i++) begin
         i_pll_loop_model.set_lock(1'b0);
         settle;
         i_pll_loop_model.set_lock(1'b1);
         settle;
      end
      rd(5'h0c, 8'h0f, ok);
      // a write without the low byte lane must leave the counter alone
      lanes = 4'h0;
      wr(5'h0c, 8'h00, ok);
      rd(5'h0c, 8'h0f, ok);
      lanes = 4'hf;
      wr(5'h0c, 8'h00, ok);
      rd(5'h0c, 8'h00, ok);
      wr(5'h04, 8'hff, ok);
      rd(5'h04, 8'h01, ok);
      wr(5'h14, 8'h01, se);
      wr(5'h10, 8'h10, ok);
      i_pll_loop_model.set_lock(1'b0);
      settle;
      rd(5'h04, 8'h01, ok);
      wr(5'h10, 8'h04, ok);
      i_pll_loop_model.set_lock(1'b1);
      settle;
      i_pll_loop_model.set_lock(1'b0);
      settle;
      rd(5'h04, 8'h01, ok);
      wr(5'h10, 8'h01, ok);
      // raw level is low: the held lock drops only after 570 cycles
      repeat (600) @(posedge aclk);
      rd(5'h04, 8'h00, ok);
      i_pll_loop_model.set_lock(1'b1);
      repeat (400) @(posedge aclk);
      rd(5'h04, 8'h00, ok);
      repeat (300) @(posedge aclk);
      rd(5'h04, 8'h01, ok);
      close_out;
   end
endmodule
